/* File: common/bpb_defs.vh */
// Constants of the blinds push-button channel
//----------------------------------------------------------------------
// Summary of operation
//----------------------------------------------------------------------
// Summary of operation
// - Blinds channel function makes the input drive a blinds actuator.
// - New input level accepted only after stable for selected debounce.
// - Push held at least long threshold (300 ms..1 s) counts long.
// - Double-click recognised only when double-click detection enabled.
// - Double-click only if second push starts within the window.
// - Block telegrams do nothing unless blocking is enabled.
// - Block polarity: default 1 blocks, inverted setting 0 blocks.
// - Short and long pushes map to different blinds commands.
// - One-button mode: short push steps, long push moves.
// - Down mode: short push steps, long push lowers.
// - Up mode: short push steps, long push raises.
// - Stop sent on release or on next short push, as selected.
// - Power return: nothing, raise/lower now or after 5/10/15 s.
// - Ignore-block setting keeps input processing after block telegram.
// - On block set: send nothing, raise or lower.
// - On block cancel: send nothing, raise or lower.
`ifndef BPB_DEFS_VH
`define BPB_DEFS_VH

// Register byte offsets
`define BPB_OFS_CFG 8'h00
`define BPB_OFS_STATUS 8'h04
`define BPB_CFG_RESET 32'h0000_0008

// Configuration field positions
`define BPB_F_CHAN_EN 0
`define BPB_F_FUNC 1
`define BPB_F_DEB 3
`define BPB_F_LONG 6
`define BPB_F_DBL_EN 9
`define BPB_F_DBL_WIN 10
`define BPB_F_BLK_EN 13
`define BPB_F_BLK_POL 14
`define BPB_F_OPMODE 15
`define BPB_F_STOP_SHORT 17
`define BPB_F_RESTORE 18
`define BPB_F_SET_RESP 22
`define BPB_F_CAN_RESP 24

// Encodings
`define BPB_FUNC_BLINDS 2'h3
`define BPB_OP_ONE 2'h0
`define BPB_OP_DOWN 2'h1
`define BPB_OP_UP 2'h2
`define BPB_SET_IGNORE 2'h0
`define BPB_CMD_STEP 2'h0
`define BPB_CMD_MOVE 2'h1
`define BPB_CMD_STOP 2'h2

// Timing
`define BPB_CLK_HZ 50000000
`define BPB_TICK_MS 1
`define BPB_CYC_PER_MS (`BPB_CLK_HZ / 1000 * `BPB_TICK_MS)
`define BPB_LONG_BASE_MS 300
`define BPB_LONG_STEP_MS 100
`define BPB_RESTORE_STEP_MS 5000

`endif

/* File: hw/bpb_top.v */
// Blinds push-button channel with APB configuration
//
// The implementer's own choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "bpb_defs.vh"

module bpb_top #(
	parameter CYC_PER_MS = `BPB_CYC_PER_MS
) (
	// Clock and reset
	input wire mclk,
	input wire sys_rst,
	// APB slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	// Channel inputs
	input wire btn_in,
	input wire blk_tel_valid,
	input wire blk_tel_value,
	input wire pwr_restore,
	// Command to the actuator and double-click pulse
	output reg cmd_valid,
	output reg [1:0] cmd_kind,
	output reg cmd_down,
	output reg dbl_click
);

	localparam S_IDLE = 4'b0001;
	localparam S_PRESS = 4'b0010;
	localparam S_LONG = 4'b0100;
	localparam S_WAIT = 4'b1000;

	reg [31:0] cfg_reg;
	reg [31:0] tick_cnt_reg;
	reg tick_reg;
	reg db_level_reg;
	reg db_prev_reg;
	reg [13:0] db_cnt_reg;
	reg [3:0] state_reg;
	reg [3:0] state_next;
	reg [13:0] pm_cnt_reg;
	reg [13:0] pm_cnt_next;
	reg second_reg;
	reg second_next;
	reg short_evt;
	reg long_evt;
	reg rel_evt;
	reg dbl_evt;
	reg blocked_reg;
	reg moving_reg;
	reg dir_reg;
	reg [13:0] rs_cnt_reg;
	reg rs_pend_reg;
	reg rs_down_reg;
	reg [13:0] deb_ms;
	reg go;
	reg [1:0] kind;
	reg dn;
	reg push_cmd;

	//------------------------------------------------------------
	// Configuration fields
	//------------------------------------------------------------
	wire chan_en = cfg_reg[`BPB_F_CHAN_EN];
	wire [1:0] func = cfg_reg[`BPB_F_FUNC +: 2];
	wire [2:0] deb_sel = cfg_reg[`BPB_F_DEB +: 3];
	wire [2:0] long_sel = cfg_reg[`BPB_F_LONG +: 3];
	wire dbl_en = cfg_reg[`BPB_F_DBL_EN];
	wire [2:0] dbl_sel = cfg_reg[`BPB_F_DBL_WIN +: 3];
	wire blk_en = cfg_reg[`BPB_F_BLK_EN];
	wire blk_pol = cfg_reg[`BPB_F_BLK_POL];
	wire [1:0] opmode = cfg_reg[`BPB_F_OPMODE +: 2];
	wire stop_short = cfg_reg[`BPB_F_STOP_SHORT];
	wire [3:0] rs_sel = cfg_reg[`BPB_F_RESTORE +: 4];
	wire [1:0] set_resp = cfg_reg[`BPB_F_SET_RESP +: 2];
	wire [1:0] can_resp = cfg_reg[`BPB_F_CAN_RESP +: 2];

	wire active = chan_en && (func == `BPB_FUNC_BLINDS);
	// Block only when enabled and not ignored
	wire blk_act = blk_en && (set_resp != `BPB_SET_IGNORE);
	wire supp = !active || blocked_reg;
	wire [31:0] long_full = `BPB_LONG_BASE_MS + long_sel * `BPB_LONG_STEP_MS;
	wire [13:0] long_ms = long_full[13:0];
	wire [31:0] dbl_full = `BPB_LONG_BASE_MS + dbl_sel * `BPB_LONG_STEP_MS;
	wire [13:0] dbl_ms = dbl_full[13:0];
	// Delay steps of 5 s, counted in ticks
	wire [3:0] rs_mult = (rs_sel >= 4'd6) ? rs_sel - 4'd5 : rs_sel - 4'd2;
	wire [31:0] rs_full = rs_mult * `BPB_RESTORE_STEP_MS - 1;
	wire press_evt = db_level_reg && !db_prev_reg;
	wire blk_new = blk_tel_value ^ blk_pol;
	wire cur_down = (opmode == `BPB_OP_DOWN) ? 1'b1 :
		(opmode == `BPB_OP_UP) ? 1'b0 : dir_reg;

	always @*
	begin
		case (deb_sel)
			3'd0: deb_ms = 14'd30;
			3'd1: deb_ms = 14'd50;
			3'd2: deb_ms = 14'd80;
			3'd3: deb_ms = 14'd100;
			3'd4: deb_ms = 14'd200;
			3'd5: deb_ms = 14'd1000;
			3'd6: deb_ms = 14'd5000;
			default: deb_ms = 14'd10000;
		endcase
	end

	//------------------------------------------------------------
	// Millisecond tick and debounce
	//------------------------------------------------------------
	always @(posedge mclk)
	begin
		if (sys_rst)
		begin
			tick_cnt_reg <= 32'h0000_0000;
			tick_reg <= 1'b0;
			db_level_reg <= 1'b0;
			db_prev_reg <= 1'b0;
			db_cnt_reg <= 14'h0000;
		end
		else
		begin
			tick_reg <= (tick_cnt_reg == CYC_PER_MS - 1);
			if (tick_cnt_reg == CYC_PER_MS - 1)
				tick_cnt_reg <= 32'h0000_0000;
			else
				tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
			db_prev_reg <= db_level_reg;
			// Level taken only after stable delay
			if (btn_in == db_level_reg)
				db_cnt_reg <= 14'h0000;
			else if (tick_reg)
			begin
				if (db_cnt_reg + 14'h0001 >= deb_ms)
				begin
					db_level_reg <= btn_in;
					db_cnt_reg <= 14'h0000;
				end
				else
					db_cnt_reg <= db_cnt_reg + 14'h0001;
			end
		end
	end

	//------------------------------------------------------------
	// Push classification
	//------------------------------------------------------------
	always @*
	begin
		state_next = state_reg;
		pm_cnt_next = tick_reg ? pm_cnt_reg + 14'h0001 : pm_cnt_reg;
		second_next = second_reg;
		short_evt = 1'b0;
		long_evt = 1'b0;
		rel_evt = 1'b0;
		dbl_evt = 1'b0;
		case (state_reg)
			S_IDLE:
			begin
				pm_cnt_next = 14'h0000;
				if (press_evt)
				begin
					state_next = S_PRESS;
					second_next = 1'b0;
				end
			end
			S_PRESS:
			begin
				if (!db_level_reg)
				begin
					pm_cnt_next = 14'h0000;
					if (second_reg)
						state_next = S_IDLE;
					// Wait for a second click only if enabled
					else if (dbl_en)
						state_next = S_WAIT;
					else
					begin
						short_evt = 1'b1;
						state_next = S_IDLE;
					end
				end
				else if (pm_cnt_reg >= long_ms && !second_reg)
				begin
					long_evt = 1'b1;
					state_next = S_LONG;
				end
			end
			S_LONG:
			begin
				if (!db_level_reg)
				begin
					rel_evt = 1'b1;
					state_next = S_IDLE;
				end
			end
			S_WAIT:
			begin
				if (press_evt)
				begin
					dbl_evt = 1'b1;
					second_next = 1'b1;
					pm_cnt_next = 14'h0000;
					state_next = S_PRESS;
				end
				else if (pm_cnt_reg >= dbl_ms)
				begin
					short_evt = 1'b1;
					state_next = S_IDLE;
				end
			end
			default:
				state_next = S_IDLE;
		endcase
		// Inactive or blocked channel stays idle
		if (supp)
		begin
			state_next = S_IDLE;
			short_evt = 1'b0;
			long_evt = 1'b0;
			rel_evt = 1'b0;
			dbl_evt = 1'b0;
		end
	end

	//------------------------------------------------------------
	// Command selection
	//------------------------------------------------------------
	// Block and power responses win; a push in that cycle is lost
	always @*
	begin
		go = 1'b0;
		kind = `BPB_CMD_MOVE;
		dn = 1'b0;
		push_cmd = 1'b0;
		if (active && blk_tel_valid && blk_act && blk_new != blocked_reg)
		begin
			if (blk_new && set_resp[1])
			begin
				go = 1'b1;
				dn = set_resp[0];
			end
			else if (!blk_new && can_resp != 2'h0)
			begin
				go = 1'b1;
				dn = can_resp[1];
			end
		end
		else if (active && rs_pend_reg && tick_reg && rs_cnt_reg == 14'h0000)
		begin
			go = 1'b1;
			dn = rs_down_reg;
		end
		else if (active && pwr_restore && (rs_sel == 4'd1 || rs_sel == 4'd2))
		begin
			go = 1'b1;
			dn = (rs_sel == 4'd2);
		end
		// Stop on short push or release
		else if ((short_evt && moving_reg && stop_short) ||
			(rel_evt && moving_reg && !stop_short))
		begin
			go = 1'b1;
			push_cmd = 1'b1;
			kind = `BPB_CMD_STOP;
			dn = cur_down;
		end
		else if (short_evt)
		begin
			go = 1'b1;
			push_cmd = 1'b1;
			kind = `BPB_CMD_STEP;
			dn = cur_down;
		end
		else if (long_evt)
		begin
			go = 1'b1;
			push_cmd = 1'b1;
			dn = cur_down;
		end
	end

	//------------------------------------------------------------
	// Channel state and outputs
	//------------------------------------------------------------
	always @(posedge mclk)
	begin
		if (sys_rst)
		begin
			state_reg <= S_IDLE;
			pm_cnt_reg <= 14'h0000;
			second_reg <= 1'b0;
			blocked_reg <= 1'b0;
			moving_reg <= 1'b0;
			dir_reg <= 1'b0;
			rs_cnt_reg <= 14'h0000;
			rs_pend_reg <= 1'b0;
			rs_down_reg <= 1'b0;
			cmd_valid <= 1'b0;
			cmd_kind <= 2'h0;
			cmd_down <= 1'b0;
			dbl_click <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			pm_cnt_reg <= pm_cnt_next;
			second_reg <= second_next;
			dbl_click <= dbl_evt;
			cmd_valid <= go;
			if (go)
			begin
				cmd_kind <= kind;
				cmd_down <= dn;
			end
			if (!blk_act || !active)
				blocked_reg <= 1'b0;
			else if (blk_tel_valid)
				blocked_reg <= blk_new;
			if (supp)
				moving_reg <= 1'b0;
			else if (push_cmd && kind == `BPB_CMD_MOVE)
			begin
				moving_reg <= 1'b1;
				// One button alternates direction
				if (opmode == `BPB_OP_ONE)
					dir_reg <= !dir_reg;
			end
			else if (push_cmd)
				moving_reg <= 1'b0;
			// Arm or count the delayed response
			if (!active)
				rs_pend_reg <= 1'b0;
			else if (pwr_restore && rs_sel >= 4'd3 && rs_sel <= 4'd8)
			begin
				rs_pend_reg <= 1'b1;
				rs_down_reg <= (rs_sel >= 4'd6);
				rs_cnt_reg <= rs_full[13:0];
			end
			else if (pwr_restore)
				rs_pend_reg <= 1'b0;
			else if (rs_pend_reg && tick_reg)
			begin
				if (rs_cnt_reg == 14'h0000)
					rs_pend_reg <= 1'b0;
				else
					rs_cnt_reg <= rs_cnt_reg - 14'h0001;
			end
		end
	end

	//------------------------------------------------------------
	// APB slave
	//------------------------------------------------------------
	// Zero wait states: answer in the first access cycle
	wire setup = psel && !penable;
	wire hit_cfg = (paddr == `BPB_OFS_CFG);
	wire hit_st = (paddr == `BPB_OFS_STATUS);

	always @(posedge mclk)
	begin
		if (sys_rst)
		begin
			cfg_reg <= `BPB_CFG_RESET;
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready <= setup;
			pslverr <= setup && !hit_cfg && !(hit_st && !pwrite);
			if (setup && !pwrite)
			begin
				if (hit_cfg)
					prdata <= cfg_reg;
				else if (hit_st)
					prdata <= {26'h000_0000, rs_pend_reg, dir_reg,
						moving_reg, blocked_reg, active, db_level_reg};
				else
					prdata <= 32'h0000_0000;
			end
			if (psel && penable && pready && pwrite && hit_cfg)
				cfg_reg <= {6'h00, pwdata[25:0]};
		end
	end

endmodule // bpb_top
`default_nettype wire

/* File: test/bpb_top_properties.sv */
// Checker of the blinds push-button channel ports
`timescale 1ns/1ps
`default_nettype none
module bpb_chk #(
	parameter CYC_PER_MS = 5
) (
	// Clock and reset
	input wire mclk,
	input wire sys_rst,
	// APB
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	// Channel
	input wire btn_in,
	input wire blk_tel_valid,
	input wire blk_tel_value,
	input wire pwr_restore,
	input wire cmd_valid,
	input wire [1:0] cmd_kind,
	input wire cmd_down,
	input wire dbl_click
);
	// Shadow of config and block state, snooped from the bus
	reg [31:0] cfg_reg;
	reg blk_reg;
	wire hit = psel & penable & pready & pwrite & (paddr == 8'h00);
	wire tel = blk_tel_valid & cfg_reg[13];
	wire lvl = blk_tel_value ^ cfg_reg[14];
	wire act = cfg_reg[0] & (cfg_reg[2:1] == 2'h3);
	wire blkd = blk_reg & cfg_reg[13] & (cfg_reg[23:22] != 2'h0);
	always @(posedge mclk)
	begin
		if (sys_rst)
		begin
			cfg_reg <= 32'h0000_0008;
			blk_reg <= 1'b0;
		end
		else
		begin
			if (hit)
				cfg_reg <= {6'h00, pwdata[25:0]};
			// Block state drops whenever blocking cannot act
			if (!(cfg_reg[13] && cfg_reg[23:22] != 2'h0 && act))
				blk_reg <= 1'b0;
			else if (tel)
				blk_reg <= lvl;
		end
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	AST_APB_READY: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	AST_KIND_HOLD: assert property ($changed(cmd_kind) |-> cmd_valid)
		else $error("kind moved without command");
	AST_DOWN_HOLD: assert property ($changed(cmd_down) |-> cmd_valid)
		else $error("direction moved without command");
	AST_DBL_EN: assert property (dbl_click |-> cfg_reg[9])
		else $error("double-click while disabled");
	AST_DBL_PULSE: assert property (dbl_click |=> !dbl_click)
		else $error("double-click pulse too long");
	AST_PUSH_CMD: assert property (cmd_valid && cmd_kind != 2'h1
		|-> $past(act) && !$past(blkd)) else $error("push command while idle");
	AST_BLK_SET: assert property (tel && !blkd && lvl && act
		&& cfg_reg[23] |=> cmd_valid && cmd_kind == 2'h1
		&& cmd_down == $past(cfg_reg[22])) else $error("no block response");
	AST_BLK_CAN: assert property (tel && blkd && !lvl && act
		&& ^cfg_reg[25:24] |=> cmd_valid && cmd_kind == 2'h1
		&& cmd_down == $past(cfg_reg[25])) else $error("no cancel response");
	AST_RESTORE: assert property (pwr_restore && !blk_tel_valid
		&& act && !blkd && cfg_reg[21:18] == 4'h2
		|=> cmd_valid && cmd_down) else $error("no restore response");
	cover property (cmd_valid && cmd_kind == 2'h2);
	cover property (dbl_click);
	cover property (pslverr);
endmodule // bpb_chk
bind bpb_top bpb_chk #(.CYC_PER_MS(CYC_PER_MS)) u_bpb_chk (.mclk(mclk),
	.sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .btn_in(btn_in), .blk_tel_valid(blk_tel_valid),
	.blk_tel_value(blk_tel_value), .pwr_restore(pwr_restore),
	.cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_down(cmd_down),
	.dbl_click(dbl_click));
`default_nettype wire

/* File: test/bpb_act_model.sv */
// Behavioural blinds actuator logging received commands
`timescale 1ns/1ps
`default_nettype none
module bpb_act_model (
	// Clock and reset
	input wire mclk,
	input wire sys_rst,
	// Commands
	input wire cmd_valid,
	input wire [1:0] cmd_kind,
	input wire cmd_down,
	// Log
	output logic [7:0] cnt,
	output logic [2:0] last,
	output logic [2:0] prev
);
	// Keeps two deep history; older commands drop out
	always @(posedge mclk)
	begin
		if (sys_rst)
		begin
			cnt <= 8'h00;
			last <= 3'h0;
			prev <= 3'h0;
		end
		else if (cmd_valid)
		begin
			cnt <= cnt + 8'h01;
			prev <= last;
			last <= {cmd_down, cmd_kind};
		end
	end
endmodule // bpb_act_model
`default_nettype wire

/* File: test/blinds_pushbutton_input_tb_top.sv */
// Testbench of the blinds push-button channel
`timescale 1ns/1ps
`default_nettype none
`define CHK(g,e) begin comparisons++; if ((g) !== (e)) begin err_count++; \
$display("Error t=%0t got %h exp %h", $time, g, e); end end
module blinds_pushbutton_input_tb_top;
	logic mclk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
	logic btn_in = 0, blk_tel_valid = 0, blk_tel_value = 0, pwr_restore = 0;
	logic [7:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic pready, pslverr, cmd_valid, cmd_down, dbl_click, er;
	logic [1:0] cmd_kind;
	logic [7:0] cnt, c, d, dc = '0;
	logic [2:0] last, prev;
	int err_count = 0, comparisons = 0;
	always #10 mclk = ~mclk;
	always @(posedge mclk)
		if (dbl_click)
			dc <= dc + 8'h01;
	// Short ms count keeps the run small
	bpb_top #(.CYC_PER_MS(5)) u_bpb_top (.mclk(mclk), .sys_rst(sys_rst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .btn_in(btn_in), .blk_tel_valid(blk_tel_valid),
		.blk_tel_value(blk_tel_value), .pwr_restore(pwr_restore),
		.cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_down(cmd_down),
		.dbl_click(dbl_click));
	bpb_act_model u_bpb_act_model (.mclk(mclk), .sys_rst(sys_rst),
		.cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_down(cmd_down),
		.cnt(cnt), .last(last), .prev(prev));
	task finish_test;
		$display("comparisons %0d errors %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] v);
		int n;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= v;
		@(posedge mclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge mclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n == 20)
		begin
			err_count++;
			finish_test();
		end
	endtask
	task cfg(input logic [31:0] v);
		apb(1'b1, 8'h00, v);
	endtask
	task push(input int h, input int g);
		btn_in <= 1'b1;
		cyc(h * 5);
		btn_in <= 1'b0;
		cyc(g * 5);
	endtask
	task tel(input logic v);
		blk_tel_valid <= 1'b1;
		blk_tel_value <= v;
		cyc(1);
		blk_tel_valid <= 1'b0;
		cyc(4);
	endtask
	task pwr;
		pwr_restore <= 1'b1;
		cyc(1);
		pwr_restore <= 1'b0;
		cyc(4);
	endtask
	task t_regs;
		apb(1'b0, 8'h00, '0);
		`CHK(rd, 32'h0000_0008)
		apb(1'b0, 8'h04, '0);
		`CHK(rd[1], 1'b0)
		apb(1'b1, 8'h04, '0);
		`CHK(er, 1'b1)
		apb(1'b0, 8'h08, '0);
		`CHK(er, 1'b1)
		$display("test regs done");
	endtask
	task t_modes;
		for (int m = 0; m < 3; m++)
		begin
			cfg(32'h0000_0007 | (m << 15));
			c = cnt;
			push(100, 150);
			`CHK(cnt - c, 8'h01)
			`CHK(last[1:0], 2'h0)
			push(500, 150);
			`CHK(cnt - c, 8'h03)
			`CHK(prev[1:0], 2'h1)
			`CHK(last[1:0], 2'h2)
			if (m > 0)
				`CHK(prev[2], m == 1)
		end
		cfg(32'h0000_8087);
		c = cnt;
		push(400, 150);
		`CHK(cnt - c, 8'h01)
		`CHK(last[1:0], 2'h0)
		$display("test modes done");
	endtask
	task t_stop;
		cfg(32'h0002_8007);
		c = cnt;
		push(500, 150);
		`CHK(cnt - c, 8'h01)
		push(100, 150);
		`CHK(last[1:0], 2'h2)
		$display("test stop done");
	endtask
	task t_dbl;
		cfg(32'h0000_0207);
		d = dc;
		push(80, 80);
		push(80, 500);
		`CHK(dc - d, 8'h01)
		c = cnt;
		push(80, 500);
		push(80, 500);
		`CHK(dc - d, 8'h01)
		`CHK(cnt - c, 8'h02)
		cfg(32'h0000_0007);
		c = cnt;
		push(80, 80);
		push(80, 200);
		`CHK(dc - d, 8'h01)
		`CHK(cnt - c, 8'h02)
		$display("test dbl done");
	endtask
	task t_blk;
		cfg(32'h01C0_2007);
		c = cnt;
		tel(1'b1);
		`CHK(last, 3'h5)
		push(100, 150);
		`CHK(cnt - c, 8'h01)
		tel(1'b0);
		`CHK(last, 3'h1)
		cfg(32'h01C0_6007);
		tel(1'b0);
		`CHK(last, 3'h5)
		tel(1'b1);
		`CHK(last, 3'h1)
		cfg(32'h01C0_0007);
		c = cnt;
		tel(1'b1);
		push(100, 150);
		`CHK(cnt - c, 8'h01)
		cfg(32'h0000_2007);
		tel(1'b1);
		push(100, 150);
		`CHK(cnt - c, 8'h02)
		$display("test blk done");
	endtask
	task t_pwr;
		cfg(32'h0008_0007);
		pwr();
		`CHK(last, 3'h5)
		cfg(32'h000C_0007);
		c = cnt;
		pwr();
		cyc(24900);
		`CHK(cnt - c, 8'h00)
		cyc(200);
		`CHK(last, 3'h1)
		$display("test pwr done");
	endtask
	task t_off;
		c = cnt;
		cfg(32'h0000_0006);
		push(500, 150);
		`CHK(cnt - c, 8'h00)
		cfg(32'h0000_0003);
		push(500, 150);
		`CHK(cnt - c, 8'h00)
		$display("test off done");
	endtask
	initial
	begin
		cyc(2);
		sys_rst <= 1'b0;
		t_regs();
		t_modes();
		t_stop();
		t_dbl();
		t_blk();
		t_pwr();
		t_off();
		finish_test();
	end
endmodule // blinds_pushbutton_input_tb_top
`default_nettype wire
